// ---- rtl/angle_sensor_pkg.sv ----
// shared constants and types for the angle sensor register bank
package angle_sensor_pkg;
   localparam logic [6:0] SLAVE_ADDR = 7'h36;
   localparam logic [7:0] ADDR_BURN_COUNT = 8'h00;
   localparam logic [7:0] ADDR_START_HI = 8'h01;
   localparam logic [7:0] ADDR_START_LO = 8'h02;
   localparam logic [7:0] ADDR_STOP_HI = 8'h03;
   localparam logic [7:0] ADDR_STOP_LO = 8'h04;
   localparam logic [7:0] ADDR_SPAN_HI = 8'h05;
   localparam logic [7:0] ADDR_SPAN_LO = 8'h06;
   localparam logic [7:0] ADDR_CFG_HI = 8'h07;
   localparam logic [7:0] ADDR_CFG_LO = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0b;
   localparam logic [7:0] ADDR_RAW_HI = 8'h0c;
   localparam logic [7:0] ADDR_RAW_LO = 8'h0d;
   localparam logic [7:0] ADDR_SCALED_HI = 8'h0e;
   localparam logic [7:0] ADDR_SCALED_LO = 8'h0f;
   localparam logic [7:0] ADDR_GAIN = 8'h1a;
   localparam logic [7:0] ADDR_MAG_HI = 8'h1b;
   localparam logic [7:0] ADDR_MAG_LO = 8'h1c;
   localparam logic [7:0] ADDR_OTP_CMD = 8'hff;
   localparam logic [7:0] CMD_BURN_ANGLE = 8'h80;
   localparam logic [7:0] CMD_BURN_SETTING = 8'h40;
   localparam logic [7:0] CMD_LOAD_A = 8'h01;
   localparam logic [7:0] CMD_LOAD_B = 8'h11;
   localparam logic [7:0] CMD_LOAD_C = 8'h10;
   localparam logic [1:0] MAX_ANGLE_BURNS = 2'h3;
   localparam int STATUS_STRONG_BIT = 3;
   localparam int STATUS_WEAK_BIT = 4;
   localparam int STATUS_DETECT_BIT = 5;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [11:0] ANGLE_MAX = 12'hfff;
   localparam logic [4:0] DIV_STEPS = 5'h18;

   typedef enum logic [1:0] {
      NOMINAL_POWER, LOW_POWER_ONE, LOW_POWER_TWO, LOW_POWER_THREE
   } power_mode_t;
   typedef enum logic [1:0] {
      ANALOG_FULL, ANALOG_LIMITED, PWM_DIGITAL, STAGE_UNUSED
   } output_stage_t;
   typedef struct packed {
      logic [1:0] reservedBits;
      logic watchdogEnable;
      logic [2:0] fastFilterThreshold;
      logic [1:0] slowFilterField;
      logic [1:0] pulseFrequencyField;
      output_stage_t outputStageField;
      logic [1:0] hysteresisField;
      power_mode_t powerModeField;
   } cfg_t;
   typedef struct packed {
      logic magnetDetected;
      logic magnetWeak;
      logic magnetStrong;
   } magnet_t;
   typedef struct packed {
      logic [1:0] burnCount;
      logic settingsDone;
      logic [15:0] startPos;
      logic [15:0] stopPos;
      logic [15:0] maxSpan;
      logic [15:0] configVal;
   } otp_image_t;
   localparam otp_image_t OTP_BLANK = '0;
   typedef enum logic [2:0] {
      BUS_IDLE, GET_ADDR, ACK_ADDR, GET_PTR, GET_DATA, ACK_RX,
      SEND_DATA, GET_MACK
   } bus_state_t;
endpackage : angle_sensor_pkg

// ---- rtl/angle_scaler.sv ----
// maps the raw angle onto the configured angular range
module angle_scaler
   import angle_sensor_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [11:0] rawAngle,
   input wire logic [11:0] startPos,
   input wire logic [11:0] stopPos,
   input wire logic [11:0] maxSpan,
   output logic [11:0] scaled
);
   logic [11:0] offset;
   logic [11:0] range;
   logic fullCircle;
   logic [12:0] remShift;
   logic [23:0] num_r;
   logic [12:0] rem_r;
   logic [23:0] quo_r;
   logic [11:0] den_r;
   logic [4:0] step_r;
   logic busy_r;
   logic done_r;

   always_comb
   begin
      offset = rawAngle - startPos;
      if (maxSpan != 12'h000)
         range = maxSpan;
      else
         range = stopPos - startPos;
      // nothing narrowed, or a degenerate range: whole circle
      fullCircle = ((maxSpan == 12'h000) && (stopPos == 12'h000)) ||
                   (range == 12'h000);
      remShift = {rem_r[11:0], num_r[23]};
   end

   // serial divide keeps area small; result lags input by ~26 cycles
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
         step_r <= 5'h00;
         num_r <= 24'h000000;
         rem_r <= 13'h0000;
         quo_r <= 24'h000000;
         den_r <= 12'h000;
         scaled <= 12'h000;
      end
      else if (!busy_r)
      begin
         if (done_r)
         begin
            scaled <= quo_r[11:0];
            done_r <= 1'b0;
         end
         else if (fullCircle)
            scaled <= offset;
         else if (offset >= range)
            scaled <= ANGLE_MAX;
         else
         begin
            // full resolution spread over the narrowed range
            num_r <= 24'(offset) * 24'(ANGLE_MAX);
            den_r <= range;
            rem_r <= 13'h0000;
            quo_r <= 24'h000000;
            step_r <= DIV_STEPS;
            busy_r <= 1'b1;
         end
      end
      else
      begin
         num_r <= {num_r[22:0], 1'b0};
         if (remShift >= {1'b0, den_r})
         begin
            rem_r <= remShift - {1'b0, den_r};
            quo_r <= {quo_r[22:0], 1'b1};
         end
         else
         begin
            rem_r <= remShift;
            quo_r <= {quo_r[22:0], 1'b0};
         end
         step_r <= step_r - 5'h01;
         if (step_r == 5'h01)
         begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
         end
      end
   end
endmodule : angle_scaler

// ---- rtl/otp_store.sv ----
// one-time-programmable image of the range and settings
module otp_store
   import angle_sensor_pkg::*;
#(
   parameter otp_image_t FACTORY_IMAGE = OTP_BLANK
)
(
   input wire logic core_clk,
   input wire logic burnAngle,
   input wire logic burnSetting,
   input wire logic magnetDetected,
   input wire logic [15:0] startPos,
   input wire logic [15:0] stopPos,
   input wire logic [15:0] maxSpan,
   input wire logic [15:0] configVal,
   output otp_image_t image
);
   // fuses survive the logic reset, so they take no reset term
   otp_image_t fuse_r = FACTORY_IMAGE;

   assign image = fuse_r;

   // a fuse can only be blown, never cleared, except burnCount, which counts up
   always_ff @(posedge core_clk)
   begin
      if (burnAngle && magnetDetected &&
          fuse_r.burnCount != MAX_ANGLE_BURNS)
      begin
         fuse_r.startPos <= fuse_r.startPos | startPos;
         fuse_r.stopPos <= fuse_r.stopPos | stopPos;
         fuse_r.burnCount <= fuse_r.burnCount + 2'h1;
      end
      if (burnSetting && !fuse_r.settingsDone)
      begin
         fuse_r.configVal <= fuse_r.configVal | configVal;
         if (fuse_r.burnCount == 2'h0)
            fuse_r.maxSpan <= fuse_r.maxSpan | maxSpan;
         fuse_r.settingsDone <= 1'b1;
      end
   end
endmodule : otp_store

// ---- rtl/angle_sensor_register_bank.sv ----
// two-wire slave and register bank of the rotary angle sensor
// Functional notes
// - registers reached over two-wire bus, slave address 0x36.
// - one-time-programmable storage keeps configuration across power cycles.
// - start, stop, span are 12-bit, high nibble then low byte.
// - no range set gives full circle; else output scaled onto range.
// - power-up loads programmed values; unprogrammed bits read zero.
// - configuration word 14 bits at 0x07 high and 0x08 low.
// - bits 1:0 select nominal or one of three low-power modes.
// - bits 3:2 set hysteresis off, one, two or three LSBs.
// - bits 5:4 pick full analog, 10-90% analog, or PWM.
// - bits 7:6 set PWM frequency 115, 230, 460, 920 Hz.
// - bits 9:8 set slow filter 16x, 8x, 4x, 2x.
// - bits 12:10 set fast filter threshold; zero means slow only.
// - bit 13 enables the watchdog.
// - write 0x80 or 0x40 to 0xFF burns; location write-only.
// - unscaled angle is raw; scaled angle mapped onto range.
// - burn counter counts angle burns; at most three allowed.
// - span burns only with counter zero; settings burn once.
// - status flags show magnet too strong, too weak, detected.
module angle_sensor_register_bank
   import angle_sensor_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic [11:0] rawAngle,
   input magnet_t magnetState,
   input wire logic [7:0] gainLevel,
   input wire logic [11:0] cordicMagnitude,
   output cfg_t configWord,
   output logic [11:0] scaledAngle
);
   logic [1:0] sclSync_r;
   logic [1:0] sdaSync_r;
   logic sclPrev_r;
   logic sdaPrev_r;
   logic scl;
   logic sda;
   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;

   bus_state_t state_r;
   logic [3:0] bitCnt_r;
   logic [7:0] shift_r;
   logic [7:0] txShift_r;
   logic [7:0] ptr_r;
   logic isRead_r;
   logic masterAck_r;
   logic sdaOe_r;
   logic wrStb_r;
   logic [7:0] wrAddr_r;
   logic [7:0] wrData_r;

   logic [15:0] start_r;
   logic [15:0] stop_r;
   logic [15:0] span_r;
   logic [15:0] config_r;
   logic [7:0] rdByte;
   logic [7:0] statusByte;
   logic cmdWrite;
   logic burnAngle;
   logic burnSetting;
   logic reload;
   otp_image_t otpImage;
   logic [11:0] scaledOut;

   function automatic logic isWritable(input logic [7:0] a);
      return (a >= ADDR_START_HI && a <= ADDR_CFG_LO) ||
             a == ADDR_OTP_CMD;
   endfunction : isWritable

   function automatic logic isMapped(input logic [7:0] a);
      return a <= ADDR_CFG_LO ||
             (a >= ADDR_STATUS && a <= ADDR_SCALED_LO) ||
             (a >= ADDR_GAIN && a <= ADDR_MAG_LO) ||
             a == ADDR_OTP_CMD;
   endfunction : isMapped

   // bus pins come from another domain; second stage feeds logic
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sclSync_r <= 2'h3;
         sdaSync_r <= 2'h3;
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end
      else
      begin
         sclSync_r <= {sclSync_r[0], sclIn};
         sdaSync_r <= {sdaSync_r[0], sdaIn};
         sclPrev_r <= sclSync_r[1];
         sdaPrev_r <= sdaSync_r[1];
      end
   end

   assign scl = sclSync_r[1];
   assign sda = sdaSync_r[1];
   assign sclRise = scl & ~sclPrev_r;
   assign sclFall = ~scl & sclPrev_r;
   assign startCond = scl & sclPrev_r & sdaPrev_r & ~sda;
   assign stopCond = scl & sclPrev_r & ~sdaPrev_r & sda;

   // byte engine; sda only changes on scl falling edges
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_r <= BUS_IDLE;
         bitCnt_r <= 4'h0;
         shift_r <= 8'h00;
         txShift_r <= 8'h00;
         ptr_r <= 8'h00;
         isRead_r <= 1'b0;
         masterAck_r <= 1'b0;
         sdaOe_r <= 1'b0;
         wrStb_r <= 1'b0;
         wrAddr_r <= 8'h00;
         wrData_r <= 8'h00;
      end
      else
      begin
         wrStb_r <= 1'b0;
         if (stopCond)
         begin
            state_r <= BUS_IDLE;
            sdaOe_r <= 1'b0;
         end
         else if (startCond)
         begin
            state_r <= GET_ADDR;
            bitCnt_r <= 4'h0;
            sdaOe_r <= 1'b0;
         end
         else if (sclRise)
         begin
            if (state_r == GET_MACK)
               masterAck_r <= ~sda;
            else if (state_r == GET_ADDR || state_r == GET_PTR ||
                     state_r == GET_DATA || state_r == SEND_DATA)
            begin
               shift_r <= {shift_r[6:0], sda};
               bitCnt_r <= bitCnt_r + 4'h1;
            end
         end
         else if (sclFall)
         begin
            case (state_r)
               GET_ADDR:
                  if (bitCnt_r == BYTE_BITS)
                  begin
                     if (shift_r[7:1] == SLAVE_ADDR)
                     begin
                        state_r <= ACK_ADDR;
                        isRead_r <= shift_r[0];
                        sdaOe_r <= 1'b1;
                     end
                     else
                        state_r <= BUS_IDLE;
                  end
               ACK_ADDR:
               begin
                  bitCnt_r <= 4'h0;
                  if (isRead_r)
                  begin
                     state_r <= SEND_DATA;
                     txShift_r <= rdByte;
                     sdaOe_r <= ~rdByte[7];
                  end
                  else
                  begin
                     state_r <= GET_PTR;
                     sdaOe_r <= 1'b0;
                  end
               end
               GET_PTR:
                  if (bitCnt_r == BYTE_BITS)
                  begin
                     ptr_r <= shift_r;
                     sdaOe_r <= isMapped(shift_r);
                     state_r <= ACK_RX;
                  end
               GET_DATA:
                  if (bitCnt_r == BYTE_BITS)
                  begin
                     // unmapped or read-only: no ack, no store
                     sdaOe_r <= isWritable(ptr_r);
                     wrStb_r <= isWritable(ptr_r);
                     wrAddr_r <= ptr_r;
                     wrData_r <= shift_r;
                     ptr_r <= ptr_r + 8'h01;
                     state_r <= ACK_RX;
                  end
               ACK_RX:
               begin
                  sdaOe_r <= 1'b0;
                  bitCnt_r <= 4'h0;
                  state_r <= GET_DATA;
               end
               SEND_DATA:
                  if (bitCnt_r == BYTE_BITS)
                  begin
                     sdaOe_r <= 1'b0;
                     ptr_r <= ptr_r + 8'h01;
                     state_r <= GET_MACK;
                  end
                  else
                  begin
                     txShift_r <= {txShift_r[6:0], 1'b0};
                     sdaOe_r <= ~txShift_r[6];
                  end
               GET_MACK:
                  if (masterAck_r)
                  begin
                     txShift_r <= rdByte;
                     sdaOe_r <= ~rdByte[7];
                     bitCnt_r <= 4'h0;
                     state_r <= SEND_DATA;
                  end
                  else
                     state_r <= BUS_IDLE;
               default:
                  state_r <= BUS_IDLE;
            endcase
         end
      end
   end

   assign sdaOe = sdaOe_r;

   // open-drain: the pin is only ever pulled low
   always_ff @(posedge core_clk)
   begin
      sdaOut <= 1'b0;
   end

   assign cmdWrite = wrStb_r && wrAddr_r == ADDR_OTP_CMD;
   assign burnAngle = cmdWrite && wrData_r == CMD_BURN_ANGLE;
   assign burnSetting = cmdWrite && wrData_r == CMD_BURN_SETTING;
   assign reload = cmdWrite && (wrData_r == CMD_LOAD_A ||
                   wrData_r == CMD_LOAD_B || wrData_r == CMD_LOAD_C);

   // whole bytes are kept so reserved bits read back as written
   always_ff @(posedge core_clk)
   begin
      if (rst || reload)
      begin
         start_r <= otpImage.startPos;
         stop_r <= otpImage.stopPos;
         span_r <= otpImage.maxSpan;
         config_r <= otpImage.configVal;
      end
      else if (wrStb_r)
      begin
         if (wrAddr_r == ADDR_START_HI)
            start_r[15:8] <= wrData_r;
         else if (wrAddr_r == ADDR_START_LO)
            start_r[7:0] <= wrData_r;
         else if (wrAddr_r == ADDR_STOP_HI)
            stop_r[15:8] <= wrData_r;
         else if (wrAddr_r == ADDR_STOP_LO)
            stop_r[7:0] <= wrData_r;
         else if (wrAddr_r == ADDR_SPAN_HI)
            span_r[15:8] <= wrData_r;
         else if (wrAddr_r == ADDR_SPAN_LO)
            span_r[7:0] <= wrData_r;
         else if (wrAddr_r == ADDR_CFG_HI)
            config_r[15:8] <= wrData_r;
         else if (wrAddr_r == ADDR_CFG_LO)
            config_r[7:0] <= wrData_r;
      end
   end

   // fields drive power, filter, output and watchdog logic
   assign configWord = cfg_t'(config_r);

   always_comb
   begin
      statusByte = 8'h00;
      statusByte[STATUS_STRONG_BIT] = magnetState.magnetStrong;
      statusByte[STATUS_WEAK_BIT] = magnetState.magnetWeak;
      statusByte[STATUS_DETECT_BIT] = magnetState.magnetDetected;
   end

   // command location and unmapped addresses read as zero
   always_comb
   begin
      rdByte = 8'h00;
      if (ptr_r == ADDR_BURN_COUNT)
         rdByte = {6'h00, otpImage.burnCount};
      else if (ptr_r == ADDR_START_HI)
         rdByte = start_r[15:8];
      else if (ptr_r == ADDR_START_LO)
         rdByte = start_r[7:0];
      else if (ptr_r == ADDR_STOP_HI)
         rdByte = stop_r[15:8];
      else if (ptr_r == ADDR_STOP_LO)
         rdByte = stop_r[7:0];
      else if (ptr_r == ADDR_SPAN_HI)
         rdByte = span_r[15:8];
      else if (ptr_r == ADDR_SPAN_LO)
         rdByte = span_r[7:0];
      else if (ptr_r == ADDR_CFG_HI)
         rdByte = config_r[15:8];
      else if (ptr_r == ADDR_CFG_LO)
         rdByte = config_r[7:0];
      else if (ptr_r == ADDR_STATUS)
         rdByte = statusByte;
      else if (ptr_r == ADDR_RAW_HI)
         rdByte = {4'h0, rawAngle[11:8]};
      else if (ptr_r == ADDR_RAW_LO)
         rdByte = rawAngle[7:0];
      else if (ptr_r == ADDR_SCALED_HI)
         rdByte = {4'h0, scaledOut[11:8]};
      else if (ptr_r == ADDR_SCALED_LO)
         rdByte = scaledOut[7:0];
      else if (ptr_r == ADDR_GAIN)
         rdByte = gainLevel;
      else if (ptr_r == ADDR_MAG_HI)
         rdByte = {4'h0, cordicMagnitude[11:8]};
      else if (ptr_r == ADDR_MAG_LO)
         rdByte = cordicMagnitude[7:0];
   end

   otp_store u_otp (
      .core_clk(core_clk),
      .burnAngle(burnAngle),
      .burnSetting(burnSetting),
      .magnetDetected(magnetState.magnetDetected),
      .startPos(start_r),
      .stopPos(stop_r),
      .maxSpan(span_r),
      .configVal(config_r),
      .image(otpImage)
   );

   // ranges under 18 degrees are not guarded here
   angle_scaler u_scaler (
      .core_clk(core_clk),
      .rst(rst),
      .rawAngle(rawAngle),
      .startPos(start_r[11:0]),
      .stopPos(stop_r[11:0]),
      .maxSpan(span_r[11:0]),
      .scaled(scaledOut)
   );

   assign scaledAngle = scaledOut;
endmodule : angle_sensor_register_bank

// ---- tb/host_model.sv ----
// two-wire bus master model that drives the sensor's bus pins
module host_model
(
   input wire logic core_clk,
   output logic scl,
   output logic masterOe,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      scl = 1'b1;
      masterOe = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wt

   // data moves only while scl is low, and is sampled mid high phase
   task automatic bit_io(input logic b, output logic s);
      masterOe <= ~b;
      wt(5);
      scl <= 1'b1;
      wt(5);
      s = sda;
      wt(5);
      scl <= 1'b0;
      wt(5);
   endtask : bit_io

   task automatic start();
      masterOe <= 1'b1;
      wt(5);
      scl <= 1'b0;
      wt(5);
   endtask : start

   task automatic rstart();
      masterOe <= 1'b0;
      wt(5);
      scl <= 1'b1;
      wt(5);
      start();
   endtask : rstart

   task automatic stop();
      masterOe <= 1'b1;
      wt(5);
      scl <= 1'b1;
      wt(5);
      masterOe <= 1'b0;
      wt(10);
   endtask : stop

   // burn commands to 0xff are plain byte writes through here
   task automatic tx(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], s);
      bit_io(1'b1, ack);
   endtask : tx

   // a nack on the last byte ends the read
   task automatic rx(input logic lastByte, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(lastByte, s);
   endtask : rx
endmodule : host_model

// ---- tb/angle_sensor_register_bank_asserts.sv ----
// bus pin timing and reset checks at the register bank ports
module angle_sensor_register_bank_asserts
   import angle_sensor_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic [11:0] rawAngle,
   input wire magnet_t magnetState,
   input wire logic [7:0] gainLevel,
   input wire logic [11:0] cordicMagnitude,
   input wire cfg_t configWord,
   input wire logic [11:0] scaledAngle
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_drive_low; sdaOut == 1'b0; endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("sda drive value not low");
   property p_reset_idle; $fell(rst) |-> !sdaOe [*3]; endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("sda pulled right after reset");
   property p_scaled_reset; $fell(rst) |-> scaledAngle == 12'h000;
   endproperty
   a_scaled_reset: assert property (p_scaled_reset)
      else $error("scaled angle not cleared by reset");
   // the pull only moves in the low phase, after the synchroniser
   property p_oe_change;
      $changed(sdaOe) |-> !sclIn && !$past(sclIn, 2);
   endproperty
   a_oe_change: assert property (p_oe_change)
      else $error("sda pull changed near scl high");
   property p_oe_high_stable; sclIn && $past(sclIn) |-> $stable(sdaOe);
   endproperty
   a_oe_high_stable: assert property (p_oe_high_stable)
      else $error("sda pull moved while scl high");
   property p_oe_hold; $rose(sdaOe) |=> sdaOe [*5]; endproperty
   a_oe_hold: assert property (p_oe_hold)
      else $error("sda pull too short");
   property p_oe_gap; $fell(sdaOe) |=> !sdaOe [*5]; endproperty
   a_oe_gap: assert property (p_oe_gap)
      else $error("sda release too short");
   property p_cfg_low;
      $changed(configWord) && !$past(rst) |-> !sclIn;
   endproperty
   a_cfg_low: assert property (p_cfg_low)
      else $error("configuration changed outside a bus write");
endmodule : angle_sensor_register_bank_asserts

// ---- tb/tb_top.sv ----
// register bank bench: bus reads and writes with expected values
module tb_top
   import angle_sensor_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst, sdaOut, sdaOe, masterOe, sclIn, lastAck;
   logic [11:0] rawAngle, cordicMagnitude, scaledAngle;
   logic [7:0] gainLevel, v;
   logic [13:0] c;
   magnet_t magnetState;
   cfg_t configWord;
   int fail_count = 0;
   int tests_run = 0;
   logic [7:0] rv [6] = '{8'h01, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00};
   // open drain: the pin shows the device drive only while enabled
   wire logic sdaIn = (sdaOe ? sdaOut : 1'b1) & ~masterOe;

   angle_sensor_register_bank DUT (.core_clk(core_clk), .rst(rst),
      .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .rawAngle(rawAngle), .magnetState(magnetState),
      .gainLevel(gainLevel), .cordicMagnitude(cordicMagnitude),
      .configWord(configWord), .scaledAngle(scaledAngle));
   host_model host (.core_clk(core_clk), .scl(sclIn),
      .masterOe(masterOe), .sda(sdaIn));

   task automatic chk(input string n, input logic [15:0] s, e);
      tests_run++;
      if (s !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic wr(input logic [7:0] p, d);
      logic a;
      host.start();
      host.tx({SLAVE_ADDR, 1'b0}, a);
      chk("addr ack", 16'(a), 16'h0);
      host.tx(p, a);
      host.tx(d, lastAck);
      host.stop();
   endtask : wr

   task automatic rc(input string n, input logic [7:0] p, e);
      logic a;
      logic [7:0] d;
      host.start();
      host.tx({SLAVE_ADDR, 1'b0}, a);
      host.tx(p, a);
      host.rstart();
      host.tx({SLAVE_ADDR, 1'b1}, a);
      host.rx(1'b1, d);
      host.stop();
      chk(n, 16'(d), 16'(e));
   endtask : rc

   task automatic wrap_up();
      if (fail_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   initial
   begin
      repeat (90000) @(posedge core_clk);
      fail_count++;
      wrap_up();
   end

   initial
   begin
      rst = 1'b1;
      rawAngle = 12'habc;
      magnetState = '0;
      gainLevel = 8'h00;
      cordicMagnitude = 12'h000;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (40) @(posedge core_clk);
      chk("cfg blank", configWord, 16'h0);
      chk("full circle", 16'(scaledAngle), 16'habc);
      for (int p = 0; p < 9; p++)
         rc("blank reg", 8'(p), 8'h00);
      host.start();
      host.tx({SLAVE_ADDR + 7'h01, 1'b0}, lastAck);
      host.stop();
      chk("foreign addr nack", 16'(lastAck), 16'h1);
      for (int i = 0; i < 8; i++)
      begin
         c = {i[0], i[2:0], {5{i[1:0]}}};
         // read first so the reserved bits survive the update
         host.start();
         host.tx({SLAVE_ADDR, 1'b0}, lastAck);
         host.tx(ADDR_CFG_HI, lastAck);
         host.rstart();
         host.tx({SLAVE_ADDR, 1'b1}, lastAck);
         host.rx(1'b1, v);
         host.stop();
         wr(ADDR_CFG_HI, {v[7:6], c[13:8]});
         wr(ADDR_CFG_LO, c[7:0]);
         chk("cfg word", configWord, {v[7:6], c});
         chk("power", 16'(configWord.powerModeField), 16'(i[1:0]));
         chk("band", 16'(configWord.hysteresisField), 16'(i[1:0]));
         chk("stage", 16'(configWord.outputStageField), 16'(i[1:0]));
         chk("pwm", 16'(configWord.pulseFrequencyField), 16'(i[1:0]));
         chk("slow", 16'(configWord.slowFilterField), 16'(i[1:0]));
         chk("thr", 16'(configWord.fastFilterThreshold), 16'(i[2:0]));
         chk("wdog", 16'(configWord.watchdogEnable), 16'(i[0]));
         rc("cfg lo", ADDR_CFG_LO, c[7:0]);
      end
      // range 0x800 codes wide, well over 18 degrees
      for (int p = 1; p < 7; p++)
         wr(8'(p), rv[p - 1]);
      for (int p = 1; p < 7; p++)
         rc("range reg", 8'(p), rv[p - 1]);
      rawAngle <= 12'h500;
      magnetState <= 3'b101;
      gainLevel <= 8'h5a;
      cordicMagnitude <= 12'h3c7;
      repeat (40) @(posedge core_clk);
      chk("scaled", 16'(scaledAngle), 16'h7ff);
      rc("scaled hi", ADDR_SCALED_HI, 8'h07);
      rc("scaled lo", ADDR_SCALED_LO, 8'hff);
      rc("raw hi", ADDR_RAW_HI, 8'h05);
      rc("raw lo", ADDR_RAW_LO, 8'h00);
      rc("status", ADDR_STATUS, 8'h28);
      rc("gain", ADDR_GAIN, 8'h5a);
      rc("mag hi", ADDR_MAG_HI, 8'h03);
      rc("mag lo", ADDR_MAG_LO, 8'hc7);
      wr(ADDR_RAW_HI, 8'h77);
      chk("ro nack", 16'(lastAck), 16'h1);
      rc("raw kept", ADDR_RAW_HI, 8'h05);
      wr(ADDR_BURN_COUNT, 8'h03);
      rc("count kept", ADDR_BURN_COUNT, 8'h00);
      magnetState <= 3'b010;
      wr(ADDR_OTP_CMD, CMD_BURN_ANGLE);
      rc("status weak", ADDR_STATUS, 8'h10);
      rc("no magnet burn", ADDR_BURN_COUNT, 8'h00);
      magnetState <= 3'b100;
      for (int k = 1; k < 5; k++)
      begin
         wr(ADDR_OTP_CMD, CMD_BURN_ANGLE);
         rc("burns", ADDR_BURN_COUNT, 8'(k > 3 ? 3 : k));
      end
      rc("cmd wo", ADDR_OTP_CMD, 8'h00);
      wr(ADDR_SPAN_HI, 8'h01);
      wr(ADDR_SPAN_LO, 8'h23);
      wr(ADDR_CFG_HI, 8'h15);
      wr(ADDR_CFG_LO, 8'h0f);
      chk("span clamp", 16'(scaledAngle), 16'hfff);
      wr(ADDR_OTP_CMD, CMD_BURN_SETTING);
      // a second settings burn must not add these bits
      wr(ADDR_CFG_HI, 8'h2a);
      wr(ADDR_CFG_LO, 8'hf0);
      wr(ADDR_OTP_CMD, CMD_BURN_SETTING);
      wr(ADDR_OTP_CMD, CMD_LOAD_A);
      chk("otp cfg", configWord, 16'h150f);
      rc("span unburnt", ADDR_SPAN_LO, 8'h00);
      rc("start otp", ADDR_START_HI, 8'h01);
      rc("stop otp", ADDR_STOP_HI, 8'h09);
      wrap_up();
   end
endmodule : tb_top

bind angle_sensor_register_bank angle_sensor_register_bank_asserts chk_i (
   .core_clk(core_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .rawAngle(rawAngle),
   .magnetState(magnetState), .gainLevel(gainLevel),
   .cordicMagnitude(cordicMagnitude), .configWord(configWord),
   .scaledAngle(scaledAngle));
